/* common/scc_pkg.sv */
// scc_pkg: constants, field positions and state codes for the clock controller
// assumes one 40 MHz clock; hf_clk and lf_clk arrive as synchronous ticks
//
// What this block does
// [RULE1] divide-by-4 prescaler then 21-stage divider
// [RULE2] reset and halt exit clear divider only; reset also clears the prescaler
// [RULE3] single-clock: hf_clk/256 feeds stage seven
// [RULE4] dual run/doze: stage7_source_sel picks source
// [RULE5] slow/sleep: lf_clk to stage seven, low stages stop
// [RULE6] machine cycle is four main-clock states
// [RULE7] single-clock: only hf oscillator, lf pins ports
// [RULE8] build option picks run_single or run_dual
// [RULE9] idle bit in single enters doze_single
// [RULE10] any interrupt request leaves doze_single
// [RULE11] wake takes interrupt if master enable set
// [RULE12] halt stops oscillator, ports hold or float
// [RULE13] stop bit enters halt, pin releases it
// [RULE14] warm-up then resume after halt instruction
// [RULE15] dual: both oscillators, main clock per mode
// [RULE16] machine cycle four hf or lf periods
// [RULE17] lf_osc_en starts low-frequency oscillator
// [RULE18] run_dual: cpu on hf, peripherals hf/lf
// [RULE19] slow: hf oscillator off, all on lf
// [RULE20] run_dual/slow switch only by register b
// [RULE21] doze_dual like doze_single, returns run_dual
// [RULE22] controller gates oscillators, switches main clock
// [RULE23] both oscillator enables cleared asserts reset
// [RULE24] halt_release_sel: 1 level, 0 rising edge
// [RULE25] warmup_sel picks one of two counts
// [RULE26] stage outputs are single-cycle tick enables
// [RULE27] idle bit cleared on wake, stop bit cleared at warm-up end
package scc_pkg;
	localparam int DIV_STAGES = 21;
	localparam int PRESCALE = 4;
	localparam int MCYC_STATES = 4;
	localparam int STAGE7_IDX = 6;
	// field positions
	localparam int TBT_STAGE7_BIT = 4;
	localparam int SYSA_STOP_BIT = 7;
	localparam int SYSA_RELSEL_BIT = 6;
	localparam int SYSA_RETSLOW_BIT = 5;
	localparam int SYSA_OUTHOLD_BIT = 4;
	localparam int SYSA_WUT_LSB = 2;
	localparam int SYSB_HFEN_BIT = 7;
	localparam int SYSB_LFEN_BIT = 6;
	localparam int SYSB_MAINSEL_BIT = 5;
	localparam int SYSB_IDLE_BIT = 4;
	// reset values
	localparam logic [7:0] SYSA_RST = 8'h00;
	localparam logic [7:0] TBT_RST = 8'h00;
	localparam logic [7:0] SYSB_LOW_RST = 8'h0F;
	// warm-up in divider stage-7 ticks (2^22/fc = 2^13 stage-7 ticks)
	localparam logic [15:0] WARMUP_LONG = 16'h6000;
	localparam logic [15:0] WARMUP_SHORT = 16'h2000;
	typedef enum logic [2:0] {
		ST_RUN_SINGLE = 3'b000,
		ST_DOZE_SINGLE = 3'b001,
		ST_HALT = 3'b010,
		ST_WARMUP = 3'b011,
		ST_RUN_DUAL = 3'b100,
		ST_DOZE_DUAL = 3'b101,
		ST_SLOW = 3'b110,
		ST_SLEEP = 3'b111
	} scc_state_t;
endpackage : scc_pkg

/* design/scc_divider.sv */
// scc_divider: prescaler plus 21-stage ripple-free tick divider
// assumes src ticks are one clk wide and synchronous to clk
`timescale 1ns/1ps
module scc_divider (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic hf_tick,
	input wire logic lf_tick,
	input wire logic use_lf7,
	input wire logic low_stop,
	output logic [scc_pkg::DIV_STAGES-1:0] stage_tick
);
	import scc_pkg::*;
	logic [1:0] pre_q;
	logic pre_tick;
	logic [DIV_STAGES-1:0] cnt_q;
	logic [DIV_STAGES-1:0] in_tick;
	logic [DIV_STAGES-1:0] out_tick;

	// prescaler survives divider clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pre_q <= 2'h0;
		end else if (hf_tick) begin
			pre_q <= pre_q + 2'h1; // [RULE1] [RULE2]
		end
	end
	assign pre_tick = hf_tick && (pre_q == 2'h3);

	// each stage toggles on its input tick and fires on 1->0
	genvar g;
	generate
		for (g = 0; g < DIV_STAGES; g++) begin : g_stage
			if (g == 0) begin : g_first
				assign in_tick[g] = pre_tick && !low_stop; // [RULE5]
			end else if (g == STAGE7_IDX) begin : g_seven
				assign in_tick[g] = use_lf7 ? lf_tick : out_tick[g-1]; // [RULE3] [RULE4]
			end else begin : g_mid
				assign in_tick[g] = out_tick[g-1];
			end
			assign out_tick[g] = in_tick[g] && cnt_q[g];
			always_ff @(posedge clk) begin
				if (!rst_n || clear) begin
					cnt_q[g] <= 1'b0; // [RULE2]
				end else if (in_tick[g]) begin
					cnt_q[g] <= ~cnt_q[g];
				end
			end
		end
	endgenerate
	// stages 1..6 silenced in slow/sleep
	assign stage_tick = low_stop ?
		{out_tick[DIV_STAGES-1:STAGE7_IDX], {STAGE7_IDX{1'b0}}} :
		out_tick; // [RULE5] [RULE26]
endmodule : scc_divider

/* design/scc_controller.sv */
// scc_controller: standby sequencer, oscillator gating, machine cycles
// assumes cpu writes registers with one-cycle strobes; osc ticks synchronous
`timescale 1ns/1ps
module scc_controller (
	// clock, reset and build option
	input wire logic clk,
	input wire logic rst_n,
	input wire logic dual_opt,
	// oscillator periods as one-cycle ticks
	input wire logic hf_tick,
	input wire logic lf_tick,
	// register writes, one-cycle strobes
	input wire logic [7:0] sysa_wdata,
	input wire logic sysa_we,
	input wire logic [7:0] sysb_wdata,
	input wire logic sysb_we,
	input wire logic [7:0] tbt_wdata,
	input wire logic tbt_we,
	// wake sources
	input wire logic irq_req,
	input wire logic irq_master_en,
	input wire logic halt_pin,
	// registered readback
	output logic [7:0] sysa_rdata,
	output logic [7:0] sysb_rdata,
	output logic [7:0] tbt_rdata,
	// oscillator control and main clock
	output logic hf_osc_on,
	output logic lf_osc_on,
	output logic lf_pins_as_port,
	output logic main_clk_tick,
	output logic [1:0] mcyc_state,
	output logic mcyc_end,
	// activity gates for cpu, watchdog and peripherals, then interrupt take, port float and reset out
	output logic cpu_run,
	output logic wdt_run,
	output logic periph_run,
	output logic periph_hf_en,
	output logic periph_lf_en,
	output logic take_irq,
	output logic port_float,
	output logic reset_out_n,
	// divider stage ticks for peripherals
	output logic [scc_pkg::DIV_STAGES-1:0] stage_tick
);
	import scc_pkg::*;
	// mode state
	scc_state_t state_q, state_d;
	logic dual_q;
	logic init_q;
	// system control a fields
	logic stop_q;
	logic relsel_q;
	logic retslow_q;
	logic outhold_q;
	logic [1:0] wut_q;
	// system control b fields
	logic hfen_q;
	logic lfen_q;
	logic mainsel_q;
	logic idle_q;
	// timebase control field
	logic stage7_q;
	// halt release and warm-up
	logic pin_q;
	logic release_ev;
	logic [15:0] wu_cnt_q;
	logic [15:0] wu_target;
	logic wu_done;
	logic div_clear;
	// gated oscillator ticks
	logic hf_run_tick;
	logic lf_run_tick;
	// machine cycle, wake and reset out
	logic [1:0] mc_q;
	logic osc_fail;
	logic take_irq_q;

	// decoded helpers
	function automatic logic is_low_clk(input scc_state_t s);
		return (s == ST_SLOW) || (s == ST_SLEEP);
	endfunction : is_low_clk
	function automatic logic is_doze(input scc_state_t s);
		return (s == ST_DOZE_SINGLE) || (s == ST_DOZE_DUAL) ||
			(s == ST_SLEEP);
	endfunction : is_doze
	function automatic logic is_run(input scc_state_t s);
		return (s == ST_RUN_SINGLE) || (s == ST_RUN_DUAL) ||
			(s == ST_SLOW);
	endfunction : is_run

	// gated ticks: a stopped oscillator gives no pulses
	assign hf_run_tick = hf_tick && hf_osc_on; // [RULE22]
	assign lf_run_tick = lf_tick && lf_osc_on; // [RULE22]

	// clock mode option caught after reset release
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			init_q <= 1'b1;
			dual_q <= 1'b0;
		end else if (init_q) begin
			init_q <= 1'b0;
			dual_q <= dual_opt; // [RULE8]
		end else if (sysb_we && sysb_wdata[SYSB_LFEN_BIT]) begin
			dual_q <= 1'b1; // [RULE17]
		end
	end

	// system control a: stop bit cleared by hardware when warm-up ends
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{stop_q, relsel_q, retslow_q, outhold_q} <= SYSA_RST[7:4];
			wut_q <= SYSA_RST[3:2];
		end else begin
			if (sysa_we) begin
				relsel_q <= sysa_wdata[SYSA_RELSEL_BIT]; // [RULE24]
				retslow_q <= sysa_wdata[SYSA_RETSLOW_BIT];
				outhold_q <= sysa_wdata[SYSA_OUTHOLD_BIT];
				wut_q <= sysa_wdata[SYSA_WUT_LSB+1:SYSA_WUT_LSB]; // [RULE25]
			end
			if (sysa_we && sysa_wdata[SYSA_STOP_BIT]) begin
				stop_q <= 1'b1; // [RULE13]
			end else if (state_q == ST_WARMUP && wu_done) begin
				stop_q <= 1'b0; // [RULE27]
			end
		end
	end

	// system control b: oscillator enables, clock select, idle
	always_ff @(posedge clk) begin
		if (!rst_n || init_q) begin
			hfen_q <= !(init_q && rst_n && dual_opt) || 1'b1;
			lfen_q <= init_q && rst_n && dual_opt;
			mainsel_q <= 1'b0;
			idle_q <= 1'b0;
		end else begin
			if (sysb_we) begin
				hfen_q <= sysb_wdata[SYSB_HFEN_BIT]; // [RULE22]
				lfen_q <= sysb_wdata[SYSB_LFEN_BIT]; // [RULE17]
				mainsel_q <= sysb_wdata[SYSB_MAINSEL_BIT] && dual_q; // [RULE20]
			end
			if (sysb_we && sysb_wdata[SYSB_IDLE_BIT]) begin
				idle_q <= 1'b1; // [RULE9]
			end else if (is_doze(state_q) && irq_req) begin
				idle_q <= 1'b0; // [RULE27]
			end
		end
	end

	// timebase control: stage seven source select
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage7_q <= TBT_RST[TBT_STAGE7_BIT];
		end else if (tbt_we) begin
			stage7_q <= tbt_wdata[TBT_STAGE7_BIT]; // [RULE4]
		end
	end

	// halt release pin: level or rising edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= halt_pin;
		end
	end
	assign release_ev = relsel_q ? halt_pin : (halt_pin && !pin_q); // [RULE13] [RULE24]

	// mode sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RUN_SINGLE, ST_RUN_DUAL, ST_SLOW: begin
				if (stop_q) begin
					state_d = ST_HALT; // [RULE13]
				end else if (idle_q) begin
					case (state_q)
						ST_RUN_SINGLE: begin
							state_d = ST_DOZE_SINGLE; // [RULE9]
						end
						ST_RUN_DUAL: begin
							state_d = ST_DOZE_DUAL; // [RULE21]
						end
						default: begin
							state_d = ST_SLEEP;
						end
					endcase
				end else if (state_q == ST_RUN_DUAL && mainsel_q) begin
					state_d = ST_SLOW; // [RULE20]
				end else if (state_q == ST_SLOW && !mainsel_q) begin
					state_d = ST_RUN_DUAL; // [RULE20]
				end else if (state_q == ST_RUN_SINGLE && dual_q) begin
					state_d = ST_RUN_DUAL; // [RULE17]
				end
			end
			ST_DOZE_SINGLE: begin
				if (irq_req) begin
					state_d = ST_RUN_SINGLE; // [RULE10]
				end
			end
			ST_DOZE_DUAL: begin
				if (irq_req) begin
					state_d = ST_RUN_DUAL; // [RULE21]
				end
			end
			ST_SLEEP: begin
				if (irq_req) begin
					state_d = ST_SLOW;
				end
			end
			ST_HALT: begin
				if (release_ev) begin
					state_d = ST_WARMUP; // [RULE13]
				end
			end
			ST_WARMUP: begin
				if (wu_done) begin
					if (!dual_q) begin
						state_d = ST_RUN_SINGLE; // [RULE14]
					end else if (retslow_q) begin
						state_d = ST_SLOW;
					end else begin
						state_d = ST_RUN_DUAL;
					end
				end
			end
			default: state_d = ST_RUN_SINGLE;
		endcase
	end

	// state register; option decides entry state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_RUN_SINGLE;
		end else if (init_q) begin
			state_q <= dual_opt ? ST_RUN_DUAL : ST_RUN_SINGLE; // [RULE8]
		end else begin
			state_q <= state_d;
		end
	end

	// warm-up counted on divider stage-seven ticks
	always_ff @(posedge clk) begin
		if (!rst_n || state_q != ST_WARMUP) begin
			wu_cnt_q <= 16'h0000;
		end else if (stage_tick[STAGE7_IDX] && !wu_done) begin
			wu_cnt_q <= wu_cnt_q + 16'h0001; // [RULE25]
		end
	end
	assign wu_target = wut_q[0] ? WARMUP_SHORT : WARMUP_LONG; // [RULE25]
	assign wu_done = (wu_cnt_q == wu_target);

	// divider cleared at reset and when warm-up ends
	assign div_clear = (state_q == ST_WARMUP) && wu_done; // [RULE2]

	// oscillators: hf off in halt and low-clock states
	assign hf_osc_on = hfen_q && !is_low_clk(state_q) &&
		(state_q != ST_HALT) &&
		!(state_q == ST_WARMUP && dual_q && retslow_q); // [RULE12] [RULE19]
	assign lf_osc_on = dual_q && (state_q != ST_HALT) &&
		(lfen_q || is_low_clk(state_q)); // [RULE15] [RULE7]
	assign lf_pins_as_port = !dual_q; // [RULE7] [RULE15]

	// main clock source per mode
	assign main_clk_tick = (state_q == ST_HALT || state_q == ST_WARMUP) ?
		1'b0 : (is_low_clk(state_q) ? lf_run_tick : hf_run_tick); // [RULE16]

	// four-state machine cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mc_q <= 2'h0;
		end else if (main_clk_tick) begin
			mc_q <= mc_q + 2'h1; // [RULE6] [RULE16]
		end
	end
	assign mcyc_state = mc_q;
	assign mcyc_end = main_clk_tick && (mc_q == 2'(MCYC_STATES - 1)); // [RULE6]

	// activity gates
	assign cpu_run = is_run(state_q); // [RULE9] [RULE21]
	assign wdt_run = cpu_run;
	assign periph_run = cpu_run || is_doze(state_q); // [RULE9] [RULE21]
	assign periph_hf_en = periph_run && !is_low_clk(state_q); // [RULE18]
	assign periph_lf_en = periph_run && lf_osc_on; // [RULE18] [RULE19]
	assign port_float = (state_q == ST_HALT || state_q == ST_WARMUP) &&
		!outhold_q; // [RULE12]

	// wake: interrupt taken first only with master enable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			take_irq_q <= 1'b0;
		end else begin
			take_irq_q <= is_doze(state_q) && irq_req && irq_master_en; // [RULE11]
		end
	end
	assign take_irq = take_irq_q;

	// both oscillator enables off forces reset out
	assign osc_fail = !hfen_q && !lfen_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reset_out_n <= 1'b1;
		end else begin
			reset_out_n <= !osc_fail; // [RULE23]
		end
	end

	// readback a: two low bits read as zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sysa_rdata <= SYSA_RST;
		end else begin
			sysa_rdata <= {stop_q, relsel_q, retslow_q, outhold_q,
				wut_q, 2'h0};
		end
	end

	// readback b: clock select shows the live mode, low nibble ones
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sysb_rdata <= {1'b1, 3'h0, SYSB_LOW_RST[3:0]};
		end else begin
			sysb_rdata <= {hfen_q, lfen_q, is_low_clk(state_q), idle_q,
				SYSB_LOW_RST[3:0]};
		end
	end

	// readback timebase: only the stage-seven select is kept
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tbt_rdata <= TBT_RST;
		end else begin
			tbt_rdata <= {3'h0, stage7_q, 4'h0};
		end
	end

	scc_divider u_div (
		.clk(clk),
		.rst_n(rst_n),
		.clear(div_clear),
		.hf_tick(hf_run_tick),
		.lf_tick(lf_run_tick),
		.use_lf7(is_low_clk(state_q) || (dual_q && stage7_q)),
		.low_stop(is_low_clk(state_q)),
		.stage_tick(stage_tick)
	);
endmodule : scc_controller

/* dv/scc_osc_model.sv */
// scc_osc_model: oscillator side, pulses only while enabled
// assumes one clk domain; LF_DIV clk cycles per low-frequency period
`timescale 1ns/1ps
module scc_osc_model #(
	parameter int LF_DIV = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hf_on,
	input wire logic lf_on,
	output logic hf_tick,
	output logic lf_tick
);
	logic [7:0] cnt_q;
	// free-running count sets the slow period
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= (cnt_q == 8'(LF_DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
		end
	end
	// a stopped oscillator gives no pulses
	assign hf_tick = hf_on;
	assign lf_tick = lf_on && (cnt_q == 8'h00);
endmodule : scc_osc_model

/* dv/scc_chk_props.sv */
// scc_chk: port-level properties of the clock controller
// assumes bound onto every scc_controller instance
`timescale 1ns/1ps
module scc_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic irq_req,
	input wire logic irq_master_en,
	input wire logic [7:0] sysb_rdata,
	input wire logic hf_osc_on,
	input wire logic lf_osc_on,
	input wire logic lf_pins_as_port,
	input wire logic main_clk_tick,
	input wire logic [1:0] mcyc_state,
	input wire logic mcyc_end,
	input wire logic cpu_run,
	input wire logic wdt_run,
	input wire logic take_irq,
	input wire logic reset_out_n,
	input wire logic [scc_pkg::DIV_STAGES-1:0] stage_tick
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// properties tie outputs to their causes
	property p_rst_out; (sysb_rdata[7:6] == 2'b00) |-> !reset_out_n; endproperty
	a_rst_out: assert property (p_rst_out) else $error("reset out stays high");
	property p_take; take_irq |-> cpu_run && $past(irq_master_en) && $past(irq_req); endproperty
	a_take: assert property (p_take) else $error("bad interrupt take");
	property p_mcyc; mcyc_end |-> mcyc_state == 2'h3; endproperty
	a_mcyc: assert property (p_mcyc) else $error("cycle end off state 3");
	property p_mstep; $changed(mcyc_state) |-> $past(main_clk_tick); endproperty
	a_mstep: assert property (p_mstep) else $error("state step without tick");
	property p_off; !hf_osc_on && !lf_osc_on |-> !main_clk_tick; endproperty
	a_off: assert property (p_off) else $error("main tick with osc off");
	property p_pins; lf_pins_as_port |-> !lf_osc_on; endproperty
	a_pins: assert property (p_pins) else $error("pins are port with osc on");
	property p_wdt; cpu_run |-> wdt_run; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog stopped in run");
	property p_low; !hf_osc_on && lf_osc_on && cpu_run |-> stage_tick[5:0] == 6'h00; endproperty
	a_low: assert property (p_low) else $error("low stages tick in slow");
	c_take: cover property (take_irq);
	c_rst: cover property (!reset_out_n);
	c_mcyc: cover property (mcyc_end);
endmodule : scc_chk
bind scc_controller scc_chk scc_chk_i (.*);

/* dv/testbench.sv */
// testbench: directed scenarios for scc_controller
// assumes scc_pkg compiled first; osc model gives the ticks
`timescale 1ns/1ps
module testbench;
	import scc_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, dual_opt = 1'b0, irq_req = 1'b0;
	logic irq_master_en = 1'b0, halt_pin = 1'b0;
	logic sysa_we = 1'b0, sysb_we = 1'b0, tbt_we = 1'b0;
	logic [7:0] sysa_wdata = 8'h00, sysb_wdata = 8'h00, tbt_wdata = 8'h00;
	logic [7:0] sysa_rdata, sysb_rdata, tbt_rdata;
	logic hf_tick, lf_tick, hf_osc_on, lf_osc_on, lf_pins_as_port;
	logic main_clk_tick, mcyc_end, cpu_run, wdt_run, periph_run;
	logic periph_hf_en, periph_lf_en, take_irq, port_float, reset_out_n;
	logic [1:0] mcyc_state;
	logic [DIV_STAGES-1:0] stage_tick;
	int miscompares = 0, n_tests = 0, cyc = 0;
	scc_controller scc_controller_i (.*);
	scc_osc_model scc_osc_model_i (.clk, .rst_n, .hf_on(hf_osc_on),
		.lf_on(lf_osc_on), .hf_tick, .lf_tick);
	// 40 MHz clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic report_and_stop;
		if (miscompares == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick
	// one-cycle write strobe, then wait for the state to follow
	task automatic wr(input int r, input logic [7:0] d);
		tick(1);
		sysa_wdata = d;
		sysb_wdata = d;
		tbt_wdata = d;
		sysa_we = (r == 0);
		sysb_we = (r == 1);
		tbt_we = (r == 2);
		tick(1);
		sysa_we = 1'b0;
		sysb_we = 1'b0;
		tbt_we = 1'b0;
		tick(2);
	endtask : wr
	task automatic do_reset(input logic dual);
		rst_n = 1'b0;
		dual_opt = dual;
		halt_pin = 1'b0;
		tick(16);
		rst_n = 1'b1;
		tick(2);
	endtask : do_reset
	// cycles between two pulses of one stage
	task automatic per(input int b, input int exp);
		int n;
		n = 0;
		while (stage_tick[b] !== 1'b1 && n < 1200) begin
			tick(1);
			n++;
		end
		n = 0;
		do begin
			tick(1);
			n++;
		end while (stage_tick[b] !== 1'b1 && n < 1200);
		chk(16'(n), 16'(exp));
	endtask : per
	task automatic t_single;
		chk(16'({cpu_run, lf_pins_as_port, lf_osc_on, reset_out_n}), 16'hD);
		chk(16'(sysb_rdata), 16'h8F);
		per(6, 512);
		per(0, 8);
	endtask : t_single
	task automatic t_doze(input logic [7:0] b, input logic ime);
		irq_master_en = ime;
		wr(1, b);
		chk(16'({cpu_run, wdt_run, periph_run}), 16'h1);
		irq_req = 1'b1;
		tick(1);
		chk(16'({take_irq, cpu_run}), 16'({ime, 1'b1}));
		irq_req = 1'b0;
		tick(1);
		chk(16'(sysb_rdata[4]), 16'h0);
	endtask : t_doze
	task automatic t_dual;
		int n;
		wr(1, 8'hC0);
		chk(16'({lf_osc_on, lf_pins_as_port, hf_osc_on}), 16'h5);
		chk(16'({periph_hf_en, periph_lf_en}), 16'h3);
		wr(2, 8'h10);
		chk(16'(tbt_rdata), 16'h10);
		per(6, 16);
		t_doze(8'hD0, 1'b1);
		wr(1, 8'h60);
		chk(16'({hf_osc_on, cpu_run, sysb_rdata[5]}), 16'h3);
		chk(16'({periph_hf_en, periph_lf_en}), 16'h1);
		n = 0;
		repeat (16) begin
			n += int'(main_clk_tick);
			tick(1);
		end
		chk(16'(n), 16'h2);
		wr(1, 8'hC0);
		chk(16'({hf_osc_on, sysb_rdata[5]}), 16'h2);
	endtask : t_dual
	task automatic t_halt(input logic [7:0] a);
		do_reset(1'b0);
		wr(0, a);
		chk(16'({hf_osc_on, cpu_run, port_float}), 16'h1);
		chk(16'(sysa_rdata), 16'(a));
		tick(8);
		chk(16'(cpu_run), 16'h0);
		halt_pin = 1'b1;
		tick(4);
		chk(16'({hf_osc_on, cpu_run}), 16'h2);
	endtask : t_halt
	// main sequence
	initial begin
		do_reset(1'b0);
		t_single();
		t_doze(8'h90, 1'b0);
		t_doze(8'h90, 1'b1);
		t_dual();
		wr(1, 8'h00);
		chk(16'(reset_out_n), 16'h0);
		do_reset(1'b1);
		chk(16'({cpu_run, lf_pins_as_port, lf_osc_on}), 16'h5);
		t_halt(8'h80);
		t_halt(8'hC0);
		report_and_stop();
	end
endmodule : testbench
